/* File: shared/drq_pkg.sv */
/*
  drq_pkg: constants for the dma request router and channel interrupt block.
  assumes: a 32-bit avalon-mm slave with byte addresses; routing is 16 bits wide, the other registers 8 bits.
*/
package drq_pkg;
  // block geometry
  localparam int DRQ_NUM_CHAN = 8; // dma channels
  localparam int DRQ_NUM_PAIR = 4; // selector fields, one per channel pair
  localparam int DRQ_SEL_W = 4; // width of one selector field
  localparam int DRQ_NUM_CODE = 16; // peripheral codes
  localparam int DRQ_REG_W = 16; // routing register width
  localparam int DRQ_ADDR_W = 8; // avalon byte address width

  // printed bus addresses; the index is the distance from the block base
  localparam logic [31:0] DRQ_BASE_PRINTED = 32'h5000_3580;
  localparam logic [31:0] DRQ_ROUTING_PRINTED = 32'h5000_3580;
  localparam logic [31:0] DRQ_PENDING_PRINTED = 32'h5000_3582;
  localparam logic [31:0] DRQ_CLEAR_PRINTED = 32'h5000_3584;
  localparam logic [7:0] DRQ_ROUTING_IDX = 8'h00;
  localparam logic [7:0] DRQ_PENDING_IDX = 8'h02;
  localparam logic [7:0] DRQ_CLEAR_IDX = 8'h04;
  localparam logic [7:0] DRQ_MASK_IDX = 8'h06; // interrupt mask
  localparam logic [7:0] DRQ_IRQ_EN_IDX = 8'h07; // per-channel interrupt enable
  localparam logic [7:0] DRQ_TRIG_IDX = 8'h08; // per-channel trigger select
  // byte address is four times the index
  localparam logic [7:0] DRQ_ROUTING_ADDR = 8'h00;
  localparam logic [7:0] DRQ_PENDING_ADDR = 8'h08;
  localparam logic [7:0] DRQ_CLEAR_ADDR = 8'h10;
  localparam logic [7:0] DRQ_MASK_ADDR = 8'h18;
  localparam logic [7:0] DRQ_IRQ_EN_ADDR = 8'h1c;
  localparam logic [7:0] DRQ_TRIG_ADDR = 8'h20;

  // reset values
  localparam logic [15:0] DRQ_ROUTING_RST = 16'hffff; // every field maps nothing
  localparam logic [7:0] DRQ_PENDING_RST = 8'h00;
  localparam logic [7:0] DRQ_MASK_RST = 8'h00;
  localparam logic [7:0] DRQ_IRQ_EN_RST = 8'h00;
  localparam logic [7:0] DRQ_TRIG_RST = 8'h00;

  // peripheral codes
  localparam logic [3:0] DRQ_CODE_SPI1 = 4'h0;
  localparam logic [3:0] DRQ_CODE_SPI2 = 4'h1;
  localparam logic [3:0] DRQ_CODE_UART1 = 4'h2;
  localparam logic [3:0] DRQ_CODE_UART2 = 4'h3;
  localparam logic [3:0] DRQ_CODE_I2C1 = 4'h4;
  localparam logic [3:0] DRQ_CODE_I2C2 = 4'h5;
  localparam logic [3:0] DRQ_CODE_USB = 4'h6;
  localparam logic [3:0] DRQ_CODE_PCM = 4'h8;
  localparam logic [3:0] DRQ_CODE_SRC = 4'h9;
  localparam logic [3:0] DRQ_CODE_ADC = 4'hc;
  localparam logic [3:0] DRQ_CODE_NONE = 4'hf;
  // codes with a first request, and codes with a second request
  localparam logic [15:0] DRQ_FIRST_VALID = 16'h137f;
  localparam logic [15:0] DRQ_SECOND_VALID = 16'h037f; // adc has no second request

  // bus answer states
  typedef enum logic [1:0] {
    DRQ_BUS_IDLE = 2'b01,
    DRQ_BUS_ANS = 2'b10
  } drq_bus_state_t;
endpackage : drq_pkg

/* File: rtl/drq_mux_irq.sv */
/*
  drq_mux_irq: routes peripheral dma request pairs onto channel pairs, and keeps
  the per-channel interrupt pending flags with their write-one-to-clear register.
  assumes: one clock ref_clk, synchronous active-high rst, peripheral and channel
  strobes synchronous to ref_clk, an avalon-mm master that holds its request.
*/
`timescale 1ns/100ps
module drq_mux_irq
  import drq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [DRQ_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // peripheral side, indexed by peripheral code
  input wire logic [DRQ_NUM_CODE-1:0] periph_req_first,
  input wire logic [DRQ_NUM_CODE-1:0] periph_req_second,
  output logic [DRQ_NUM_CODE-1:0] periph_ack_first,
  output logic [DRQ_NUM_CODE-1:0] periph_ack_second,
  // channel side
  input wire logic [DRQ_NUM_CHAN-1:0] chan_ack,
  input wire logic [DRQ_NUM_CHAN-1:0] chan_done,
  output logic [DRQ_NUM_CHAN-1:0] chan_go,
  // interrupt
  output logic irq
);

  // register state
  logic [DRQ_REG_W-1:0] routing_reg, routing_next; // four selector fields
  logic [DRQ_NUM_CHAN-1:0] pending_reg, pending_next; // sticky channel flags
  logic [DRQ_NUM_CHAN-1:0] mask_reg, mask_next; // gates pending onto irq
  logic [DRQ_NUM_CHAN-1:0] irq_en_reg, irq_en_next; // per-channel enable
  logic [DRQ_NUM_CHAN-1:0] trig_reg, trig_next; // per-channel trigger select
  logic [31:0] rdata_reg, rdata_next; // read data, held for the answer
  drq_bus_state_t bus_reg, bus_next; // answer state

  // decoded access strobes
  logic acc; // request accepted at this edge
  logic wr_acc; // accepted write
  logic [15:0] wmask; // byte-lane mask over the low half
  logic [15:0] wdata; // masked write data
  logic [DRQ_NUM_CHAN-1:0] clr_bits; // channels cleared by this write

  // routing nets, one entry per pair, routed_req one per channel
  logic [DRQ_SEL_W-1:0] sel [DRQ_NUM_PAIR]; // selector of each pair
  logic [DRQ_NUM_PAIR-1:0] owner; // pair owns its code
  logic [DRQ_NUM_CHAN-1:0] routed_req; // request seen by each channel

  // the master holds its request, so answering in the second cycle is enough
  assign acc = (avs_read | avs_write) & (bus_reg == DRQ_BUS_ANS);
  assign wr_acc = avs_write & acc;
  assign avs_waitrequest = (avs_read | avs_write) & (bus_reg != DRQ_BUS_ANS);
  assign avs_readdata = rdata_reg;
  assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdata = avs_writedata[15:0] & wmask;

  // clear strobes: only ones on an enabled lane act
  assign clr_bits = (wr_acc && avs_address == DRQ_CLEAR_ADDR) ?
                    wdata[DRQ_NUM_CHAN-1:0] : '0;

  // bus answer state: one wait cycle, then the answer
  always_comb begin
    bus_next = bus_reg;
    case (bus_reg)
      DRQ_BUS_IDLE: begin
        // a request starts the wait
        if (avs_read | avs_write) begin
          bus_next = DRQ_BUS_ANS;
        end
      end
      DRQ_BUS_ANS: begin
        // answer given at this edge
        bus_next = DRQ_BUS_IDLE;
      end
      default: begin
        bus_next = DRQ_BUS_IDLE;
      end
    endcase
  end

  // software registers and read data
  always_comb begin
    routing_next = routing_reg;
    mask_next = mask_reg;
    irq_en_next = irq_en_reg;
    trig_next = trig_reg;
    rdata_next = rdata_reg;
    if (wr_acc) begin
      case (avs_address)
        DRQ_ROUTING_ADDR: begin
          routing_next = (routing_reg & ~wmask) | wdata;
        end
        DRQ_MASK_ADDR: begin
          mask_next = (mask_reg & ~wmask[7:0]) | wdata[7:0];
        end
        DRQ_IRQ_EN_ADDR: begin
          irq_en_next = (irq_en_reg & ~wmask[7:0]) | wdata[7:0];
        end
        DRQ_TRIG_ADDR: begin
          trig_next = (trig_reg & ~wmask[7:0]) | wdata[7:0];
        end
        default: begin
          // clear register and unmapped words store nothing
        end
      endcase
    end
    if (avs_read & (bus_reg == DRQ_BUS_IDLE)) begin
      // latched while waitrequest is high, stands through the answer edge
      case (avs_address)
        DRQ_ROUTING_ADDR: rdata_next = {16'h0000, routing_reg};
        DRQ_PENDING_ADDR: rdata_next = {24'h00_0000, pending_reg};
        DRQ_CLEAR_ADDR: rdata_next = 32'h0000_0000;
        DRQ_MASK_ADDR: rdata_next = {24'h00_0000, mask_reg};
        DRQ_IRQ_EN_ADDR: rdata_next = {24'h00_0000, irq_en_reg};
        DRQ_TRIG_ADDR: rdata_next = {24'h00_0000, trig_reg};
        default: rdata_next = 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // pending flags: an enabled done in the clearing cycle survives, set wins
  always_comb begin
    pending_next = (pending_reg & ~clr_bits) | (chan_done & irq_en_reg);
  end

  // register everything
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_reg <= DRQ_BUS_IDLE;
      routing_reg <= DRQ_ROUTING_RST;
      pending_reg <= DRQ_PENDING_RST;
      mask_reg <= DRQ_MASK_RST;
      irq_en_reg <= DRQ_IRQ_EN_RST;
      trig_reg <= DRQ_TRIG_RST;
      rdata_reg <= 32'h0000_0000;
    end else begin
      bus_reg <= bus_next;
      routing_reg <= routing_next;
      pending_reg <= pending_next;
      mask_reg <= mask_next;
      irq_en_reg <= irq_en_next;
      trig_reg <= trig_next;
      rdata_reg <= rdata_next;
    end
  end

  // level interrupt from unmasked pending flags
  assign irq = |(pending_reg & mask_reg);

  // per-pair routing; pair p feeds channels 2p and 2p+1
  genvar p;
  generate
    for (p = 0; p < DRQ_NUM_PAIR; p++) begin : g_pair
      assign sel[p] = routing_reg[p*DRQ_SEL_W +: DRQ_SEL_W];
      // owner unless a lower field holds the same code
      always_comb begin
        owner[p] = 1'b1;
        for (int q = 0; q < p; q++) begin
          if (sel[q] == sel[p]) begin
            owner[p] = 1'b0;
          end
        end
      end
      // reserved and none codes drop out through the valid masks
      assign routed_req[2*p] = owner[p] & DRQ_FIRST_VALID[sel[p]] &
                               periph_req_first[sel[p]];
      assign routed_req[2*p+1] = owner[p] & DRQ_SECOND_VALID[sel[p]] &
                                 periph_req_second[sel[p]];
      assign chan_go[2*p] = trig_reg[2*p] ? routed_req[2*p] : 1'b1;
      assign chan_go[2*p+1] = trig_reg[2*p+1] ? routed_req[2*p+1] : 1'b1;
    end
  endgenerate

  // acknowledges go back only from the owning pair
  always_comb begin
    periph_ack_first = '0;
    periph_ack_second = '0;
    for (int k = 0; k < DRQ_NUM_PAIR; k++) begin
      if (owner[k] && DRQ_FIRST_VALID[sel[k]]) begin
        periph_ack_first[sel[k]] = chan_ack[2*k];
      end
      if (owner[k] && DRQ_SECOND_VALID[sel[k]]) begin
        periph_ack_second[sel[k]] = chan_ack[2*k+1];
      end
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // pair a carries the first request of its code to channel 0
  property p_pair_a_first;
    (trig_reg[0] && routing_reg[3:0] == DRQ_CODE_UART1) |->
      (chan_go[0] == periph_req_first[DRQ_CODE_UART1]);
  endproperty
  a_pair_a_first: assert property (p_pair_a_first) else $error("pair a first request misrouted");

  // the none code starts nothing on a triggered channel
  property p_none_code;
    (trig_reg[1] && routing_reg[3:0] == DRQ_CODE_NONE) |-> !chan_go[1];
  endproperty
  a_none_code: assert property (p_none_code) else $error("none code raised a channel");

  // adc has no second request
  property p_adc_single;
    (trig_reg[3] && routing_reg[7:4] == DRQ_CODE_ADC) |-> !chan_go[3];
  endproperty
  a_adc_single: assert property (p_adc_single) else $error("adc second request routed");

  // duplicated code: pair b stays silent, pair a owns the acknowledge
  property p_dup_owner;
    (trig_reg[2] && routing_reg[7:4] == routing_reg[3:0]) |->
      (!chan_go[2] && periph_ack_first[routing_reg[3:0]] == (chan_ack[0] &&
       DRQ_FIRST_VALID[routing_reg[3:0]]));
  endproperty
  a_dup_owner: assert property (p_dup_owner) else $error("duplicate code not owned by lowest");

  // pending read answers with zero upper bits and the flags of the edge before
  property p_pending_read;
    (avs_read && !avs_waitrequest && avs_address == DRQ_PENDING_ADDR) |->
      (avs_readdata[31:8] == 24'h00_0000 && avs_readdata[7:0] == $past(pending_reg));
  endproperty
  a_pending_read: assert property (p_pending_read) else $error("pending word read wrong");

  // a written one clears the flag unless a new done arrives
  property p_clear_one;
    (wr_acc && avs_address == DRQ_CLEAR_ADDR && avs_byteenable[0] &&
     avs_writedata[5] && !chan_done[5]) |=> !pending_reg[5];
  endproperty
  a_clear_one: assert property (p_clear_one) else $error("clear one did not clear");

  // a written zero keeps a set flag
  property p_clear_zero;
    (wr_acc && avs_address == DRQ_CLEAR_ADDR && !avs_writedata[2] && pending_reg[2]) |=>
      pending_reg[2];
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear zero changed a flag");

  // clear register reads zero
  property p_clear_reads_zero;
    (avs_read && !avs_waitrequest && avs_address == DRQ_CLEAR_ADDR) |->
      avs_readdata == 32'h0000_0000;
  endproperty
  a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear register read nonzero");

  // pair d carries the second request of its code to channel 7
  property p_pair_d_second;
    (trig_reg[7] && routing_reg[15:12] == DRQ_CODE_PCM && routing_reg[3:0] != DRQ_CODE_PCM &&
     routing_reg[7:4] != DRQ_CODE_PCM && routing_reg[11:8] != DRQ_CODE_PCM) |->
      (chan_go[7] == periph_req_second[DRQ_CODE_PCM]);
  endproperty
  a_pair_d_second: assert property (p_pair_d_second) else $error("pair d second request misrouted");

  // a done without enable never raises a clear flag
  property p_enable_gate;
    (!pending_reg[4] && chan_done[4] && !irq_en_reg[4]) |=> !pending_reg[4];
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("flag set without enable");

  // a done with enable raises the flag at the next edge
  property p_enable_set;
    (chan_done[6] && irq_en_reg[6]) |=> pending_reg[6];
  endproperty
  a_enable_set: assert property (p_enable_set) else $error("enabled done lost");

  // untriggered channels start at once
  property p_immediate;
    !trig_reg[3] |-> chan_go[3];
  endproperty
  a_immediate: assert property (p_immediate) else $error("untriggered channel not started");

endmodule : drq_mux_irq

/* File: verification/drq_periph_model.sv */
/*
  drq_periph_model: behavioural peripherals that raise dma requests, indexed by code.
  assumes: the bench says which codes want service; acks come back from the router.
*/
`timescale 1ns/100ps
module drq_periph_model
  import drq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic [DRQ_NUM_CODE-1:0] want_first,
  input wire logic [DRQ_NUM_CODE-1:0] want_second,
  input wire logic [DRQ_NUM_CODE-1:0] periph_ack_first,
  input wire logic [DRQ_NUM_CODE-1:0] periph_ack_second,
  output logic [DRQ_NUM_CODE-1:0] periph_req_first,
  output logic [DRQ_NUM_CODE-1:0] periph_req_second
);
  logic [DRQ_NUM_CODE-1:0] served_first_reg; // acked, held off until want drops
  logic [DRQ_NUM_CODE-1:0] served_second_reg; // same, second request
  logic [DRQ_NUM_CODE-1:0] quick; // prompt peripherals honour acks
  assign quick = {DRQ_NUM_CODE{!slow}};
  // a slow peripheral ignores acks and keeps asking, the harder case for the router
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      served_first_reg <= '0;
      served_second_reg <= '0;
    end else begin
      served_first_reg <= want_first & (served_first_reg | (periph_ack_first & quick));
      served_second_reg <= want_second & (served_second_reg | (periph_ack_second & quick));
    end
  end
  // request is a level while service is still wanted
  assign periph_req_first = want_first & ~served_first_reg;
  assign periph_req_second = want_second & ~served_second_reg;
endmodule : drq_periph_model

/* File: verification/test_dma_request_mux_irq_status.sv */
/*
  test_dma_request_mux_irq_status: self-checking bench for the request router and
  channel interrupt flags. assumes: drq_pkg map, one 40 MHz clock, avalon-mm master here.
*/
`timescale 1ns/100ps
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED %s exp %h got %h", what, exp, got); end end
module test_dma_request_mux_irq_status;
  import drq_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1; // clock and reset
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0, avs_write = 1'b0, irq, avs_waitrequest, slow = 1'b1;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, e; // e: oldest expected read
  logic [15:0] req_f, req_s, ack_f, ack_s, ef, es, routing; // peripheral side
  logic [15:0] want_f = 16'h0, want_s = 16'h0;
  logic [7:0] chan_ack = 8'h00, chan_done = 8'h00, chan_go, trig, exp_go; // channel side
  logic [31:0] exp_q[$]; // expected read data, oldest first
  int num_errors = 0, num_checks = 0, cycles = 0;
  always #12.5 ref_clk = ~ref_clk;
  drq_mux_irq drq_mux_irq_i (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .periph_req_first(req_f), .periph_req_second(req_s), .periph_ack_first(ack_f),
    .periph_ack_second(ack_s), .chan_ack(chan_ack), .chan_done(chan_done),
    .chan_go(chan_go), .irq(irq));
  drq_periph_model drq_periph_model_i (.ref_clk(ref_clk), .rst(rst), .slow(slow),
    .want_first(want_f), .want_second(want_s), .periph_ack_first(ack_f),
    .periph_ack_second(ack_s), .periph_req_first(req_f), .periph_req_second(req_s));
  // codes that own a first and a second request
  function automatic logic has_first(input int c);
    return c <= 6 || c == 8 || c == 9 || c == 12;
  endfunction : has_first
  function automatic logic has_second(input int c);
    return has_first(c) && c != 12; // adc has only one request
  endfunction : has_second
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // held until waitrequest is sampled low; one idle edge keeps strobes from merging
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge ref_clk iff avs_waitrequest === 1'b0);
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask : bus_write
  task automatic bus_read(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge ref_clk iff avs_waitrequest === 1'b0);
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask : bus_read
  // read data is taken at the accept edge only
  always @(posedge ref_clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      e = exp_q.pop_front();
      `CHK("readdata", e, avs_readdata)
    end
  end
  // hang guard: far above the fewer than one thousand cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(32'hede8));
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk); // combinational outputs settled mid-cycle
    `CHK("go after reset", 8'hff, chan_go)
    `CHK("irq after reset", 1'b0, irq)
    @(posedge ref_clk);
    bus_read(DRQ_ROUTING_ADDR, 32'hffff);
    bus_read(DRQ_PENDING_ADDR, 32'h0);
    bus_read(DRQ_CLEAR_ADDR, 32'h0);
    bus_read(8'h3c, 32'h0);
    $display("test reset done");
    // every code in every field, random trigger select, all peripherals asking
    want_f <= 16'hffff;
    want_s <= 16'hffff;
    for (int p = 0; p < 4; p++) begin
      for (int c = 0; c < 16; c++) begin
        trig = 8'($urandom);
        // even codes always take the triggered path, so routed requests are really seen
        if (c % 2 == 0) trig[2*p +: 2] = 2'b11;
        routing = 16'hffff;
        routing[4*p +: 4] = 4'(c);
        for (int i = 0; i < 8; i++) begin
          exp_go[i] = !trig[i] || (i / 2 == p && ((i % 2) ? has_second(c) : has_first(c)));
        end
        bus_write(DRQ_TRIG_ADDR, {24'h0, trig});
        bus_write(DRQ_ROUTING_ADDR, {16'h0, routing});
        bus_read(DRQ_ROUTING_ADDR, {16'h0, routing});
        @(negedge ref_clk);
        `CHK("routed go", exp_go, chan_go)
        @(posedge ref_clk);
        chan_ack <= 8'($urandom);
        @(negedge ref_clk);
        ef = 16'h0;
        es = 16'h0;
        ef[c] = chan_ack[2*p] & has_first(c);
        es[c] = chan_ack[2*p+1] & has_second(c);
        `CHK("first ack", ef, ack_f)
        `CHK("second ack", es, ack_s)
        @(posedge ref_clk);
        chan_ack <= 8'h00;
      end
    end
    $display("test routing done");
    // uart mapped three times: the lowest field owns it, prompt peripheral drops when acked
    slow <= 1'b0;
    bus_write(DRQ_TRIG_ADDR, 32'hff);
    bus_write(DRQ_ROUTING_ADDR, 32'hf222);
    @(negedge ref_clk);
    `CHK("duplicate go", 8'h03, chan_go)
    @(posedge ref_clk);
    chan_ack <= 8'h3e; // higher duplicates ack too, and must not be heard
    @(negedge ref_clk);
    `CHK("duplicate first ack", 16'h0000, ack_f)
    `CHK("duplicate second ack", 16'h0004, ack_s)
    @(posedge ref_clk);
    chan_ack <= 8'h00;
    @(negedge ref_clk);
    `CHK("go after served", 8'h01, chan_go)
    @(posedge ref_clk);
    $display("test duplicate done");
    // only enabled channels latch a done; clear by ones only
    bus_write(DRQ_MASK_ADDR, 32'hff);
    bus_write(DRQ_IRQ_EN_ADDR, 32'h6f);
    chan_done <= 8'hff;
    @(posedge ref_clk);
    chan_done <= 8'h00;
    bus_read(DRQ_PENDING_ADDR, 32'h006f);
    @(negedge ref_clk);
    `CHK("irq pending", 1'b1, irq)
    @(posedge ref_clk);
    bus_write(DRQ_CLEAR_ADDR, 32'hff00_0023);
    bus_read(DRQ_PENDING_ADDR, 32'h004c);
    bus_write(DRQ_MASK_ADDR, 32'h33);
    @(negedge ref_clk);
    `CHK("irq masked", 1'b0, irq)
    @(posedge ref_clk);
    bus_write(DRQ_CLEAR_ADDR, 32'hff);
    bus_read(DRQ_PENDING_ADDR, 32'h0);
    $display("test interrupts done");
    repeat (2) @(posedge ref_clk);
    complete_run();
  end
endmodule : test_dma_request_mux_irq_status
